// *** dv/rrsm_host_model.sv ***
// Bus host model turning a clear request into a remote clear pulse
module rrsm_host_model (
    input  wire logic       clk_sys,
    input  wire logic       clr_req,
    input  wire logic [2:0] delay,
    output logic            remote_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        remote_clear = 1'h0;
        forever begin
            @(posedge clk_sys iff clr_req);
            // Drive off the sampling edge, like every other design input
            repeat (delay + 1) @(negedge clk_sys);
            remote_clear = 1'h1;
            @(negedge clk_sys);
            remote_clear = 1'h0;
        end
    end
endmodule

// *** dv/rrsm_top_props.sv ***
// Port checks for the resync and sync monitor
module rrsm_top_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ref_10m_in,
    input wire logic second_tick_pulse,
    input wire logic sync_enable,
    input wire logic panel_clear_btn,
    input wire logic remote_clear,
    input wire logic ref_10m_out,
    input wire logic ref_5m_out,
    input wire logic sync_fault,
    input wire logic sync_good_led,
    input wire logic tick_lost,
    input wire logic phase_wrong
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_resync_delay: assert property (ref_10m_out == $past(ref_10m_in, 3))
        else $error("resync delay wrong");
    chk_div_on_ref: assert property ($changed(ref_5m_out) && !$rose(ref_10m_out)
        |-> $fell(ref_5m_out) && phase_wrong) else $error("divider moved without reference");
    chk_phase_forces_low: assert property ($rose(phase_wrong) && !$past(sync_enable, 3)
        |-> !ref_5m_out) else $error("divider not forced");
    chk_phase_sets_fault: assert property ($rose(phase_wrong) |-> sync_fault)
        else $error("phase error not latched");
    chk_lost_sets_fault: assert property (tick_lost |=> sync_fault)
        else $error("lost tick not latched");
    chk_disable_faults: assert property (sync_enable [*5] |-> sync_fault)
        else $error("disable not latched");
    chk_clear_cause: assert property ($fell(sync_fault)
        |-> $past(remote_clear) || $past(panel_clear_btn, 3)) else $error("clear without cause");
    chk_led_follow: assert property (sync_good_led == !$past(sync_fault))
        else $error("indicator wrong");
    chk_lost_clears: assert property ($fell(tick_lost) |-> $past(second_tick_pulse, 3))
        else $error("lost flag dropped without tick");
    chk_phase_on_tick: assert property ($changed(phase_wrong)
        |-> $past(second_tick_pulse, 3) && !$past(second_tick_pulse, 4))
        else $error("phase changed without tick");
    chk_clear_blocked: assert property ($fell(sync_fault)
        |-> !$past(tick_lost) && !$past(sync_enable, 3)) else $error("clear won over cause");
    cover property ($rose(tick_lost));
    cover property ($fell(sync_fault));
    cover property ($rose(phase_wrong));
endmodule

bind rrsm_top rrsm_top_props i_rrsm_top_props (.clk_sys(clk_sys), .rst(rst),
    .ref_10m_in(ref_10m_in), .second_tick_pulse(second_tick_pulse),
    .sync_enable(sync_enable), .panel_clear_btn(panel_clear_btn),
    .remote_clear(remote_clear), .ref_10m_out(ref_10m_out), .ref_5m_out(ref_5m_out),
    .sync_fault(sync_fault), .sync_good_led(sync_good_led), .tick_lost(tick_lost),
    .phase_wrong(phase_wrong));

// *** dv/tb_top.sv ***
// Self-checking bench for the resync and sync monitor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, ref_10m_in, second_tick_pulse, sync_enable, panel_clear_btn;
    logic        remote_clear, ref_10m_out, ref_5m_out, sync_fault, sync_good_led;
    logic        tick_lost, phase_wrong, clr_req, tick_en;
    logic [31:0] lfsr = 32'hF1936F25;
    int          n_fail = 0;
    int          n_compared = 0;
    logic [2:0]  ref_pipe;
    logic [3:0]  tick_pipe;
    rrsm_top #(.PPS_TIMEOUT_CYC(20)) i_rrsm_top (.clk_sys(clk_sys), .rst(rst),
        .ref_10m_in(ref_10m_in), .second_tick_pulse(second_tick_pulse),
        .sync_enable(sync_enable), .panel_clear_btn(panel_clear_btn),
        .remote_clear(remote_clear), .ref_10m_out(ref_10m_out), .ref_5m_out(ref_5m_out),
        .sync_fault(sync_fault), .sync_good_led(sync_good_led), .tick_lost(tick_lost),
        .phase_wrong(phase_wrong));
    rrsm_host_model i_rrsm_host_model (.clk_sys(clk_sys), .clr_req(clr_req),
        .delay(lfsr[2:0]), .remote_clear(remote_clear));
    function automatic logic [31:0] next_lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic exp_led(input logic fault);
        return !fault;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic check(input string name, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic clear_remote();
        lfsr = next_lfsr(lfsr);
        clr_req = 1'b1;
        cyc(1);
        clr_req = 1'b0;
        cyc(12);
    endtask
    task automatic press_button();
        lfsr = next_lfsr(lfsr);
        panel_clear_btn = 1'b1;
        cyc(5 + lfsr[3:0]);
        panel_clear_btn = 1'b0;
        cyc(6);
    endtask
    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // 6,6,6,7 half periods average 12.5 clocks per period, a 10 MHz reference
    initial begin
        ref_10m_in = 1'b0;
        // Waiting on the level avoids racing the release at the same edge
        wait (!rst);
        cyc(1);
        forever for (int i = 0; i < 4; i++) begin
            cyc(i == 3 ? 7 : 6);
            ref_10m_in = ~ref_10m_in;
        end
    end
    // Tick spacing of 100 clocks keeps the 5 MHz phase fixed at each tick
    initial begin
        second_tick_pulse = 1'b0;
        wait (!rst);
        cyc(1);
        forever begin
            cyc(90);
            second_tick_pulse = tick_en;
            cyc(10);
            second_tick_pulse = 1'b0;
        end
    end
    // Pin history at the design's sampling edges, cleared like its synchronisers
    always @(posedge clk_sys) begin
        if (rst) begin
            ref_pipe  <= 3'h0;
            tick_pipe <= 4'h0;
        end else begin
            ref_pipe  <= {ref_pipe[1:0], ref_10m_in};
            tick_pipe <= {tick_pipe[2:0], second_tick_pulse};
        end
    end
    always @(negedge clk_sys) begin
        if (!rst) begin
            check("ref_10m", ref_10m_out, ref_pipe[2]);
        end
        if (!rst && tick_pipe[2] && !tick_pipe[3] && !sync_enable) begin
            check("ref_5m_tick", ref_5m_out, 1'h0);
        end
    end
    initial begin
        repeat (4000) @(posedge clk_sys);
        n_fail++;
        $display("mismatch watchdog expected done seen hang");
        complete_run();
    end
    initial begin
        {rst, sync_enable, panel_clear_btn, clr_req, tick_en} = 5'h11;
        cyc(4);
        rst = 1'b0;
        check("led_rst", sync_good_led, exp_led(1'b1));
        clear_remote();
        check("fault_init_clr", sync_fault, 1'h0);
        // First tick finds the divider high with this stimulus phase
        cyc(87);
        check("phase_first", phase_wrong, 1'h1);
        check("fault_phase", sync_fault, 1'h1);
        cyc(150);
        check("phase", phase_wrong, 1'b0);
        clear_remote();
        check("fault_clr", sync_fault, 1'b0);
        check("led", sync_good_led, exp_led(1'b0));
        $display("test phase done");
        tick_en = 1'b0;
        cyc(400);
        check("lost", tick_lost, 1'b1);
        check("fault_lost", sync_fault, 1'b1);
        clear_remote();
        check("fault_held", sync_fault, 1'b1);
        tick_en = 1'b1;
        cyc(120);
        check("lost_end", tick_lost, 1'b0);
        clear_remote();
        check("fault_clr2", sync_fault, 1'b0);
        $display("test tick loss done");
        sync_enable = 1'b1;
        cyc(6);
        check("fault_dis", sync_fault, 1'b1);
        press_button();
        check("fault_dis_held", sync_fault, 1'b1);
        sync_enable = 1'b0;
        cyc(250);
        press_button();
        check("fault_btn", sync_fault, 1'b0);
        check("phase2", phase_wrong, 1'b0);
        $display("test disable done");
        complete_run();
    end
endmodule

// *** hdl/rrsm_pkg.sv ***
// Types for the reference resync and sync monitor
`include "rrsm_regs.svh"

package rrsm_pkg;
    typedef logic [`RRSM_COUNT_W-1:0] rrsm_count_t;
    typedef logic [2:0]               rrsm_cause_t;
endpackage

// *** hdl/rrsm_regs.svh ***
// Constants for the reference resync and sync monitor
`ifndef RRSM_REGS_SVH
`define RRSM_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RRSM_REF_FREQ_KHZ      10000
`define RRSM_PPS_TIMEOUT_MS    1100
`define RRSM_PPS_TIMEOUT_CYC   (`RRSM_PPS_TIMEOUT_MS * `RRSM_REF_FREQ_KHZ)
`define RRSM_COUNT_W           24

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RRSM_DIV_RST           1'h0
`define RRSM_FAULT_RST         1'h1
`define RRSM_CAUSE_RST         3'h0

// ----------------------------------------------------------------
// Fault cause bit positions
// ----------------------------------------------------------------
`define RRSM_CAUSE_PHASE       0
`define RRSM_CAUSE_LOST        1
`define RRSM_CAUSE_DISABLED    2

`endif

// *** hdl/rrsm_sync_edge.sv ***
// Two-flop synchroniser with rising-edge pulse
module rrsm_sync_edge (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_reg <= 1'h0;
            sync_reg <= 1'h0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_reg <= 1'h0;
        end else begin
            prev_reg <= sync_reg;
        end
    end

    assign level_out  = sync_reg;
    assign rise_pulse = sync_reg & ~prev_reg;
endmodule

// *** hdl/rrsm_top.sv ***
// Reference resync, divide-by-two and second-tick sync monitor
`include "rrsm_regs.svh"

module rrsm_top #(
    parameter int unsigned PPS_TIMEOUT_CYC = `RRSM_PPS_TIMEOUT_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic ref_10m_in,
    input  wire logic second_tick_pulse,
    input  wire logic sync_enable,
    input  wire logic panel_clear_btn,
    input  wire logic remote_clear,
    output logic      ref_10m_out,
    output logic      ref_5m_out,
    output logic      sync_fault,
    output logic      sync_good_led,
    output logic      tick_lost,
    output logic      phase_wrong
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Saturates rather than wraps, so an oversized limit still times out
    function automatic rrsm_pkg::rrsm_count_t clamp_limit(input int unsigned cycles);
        rrsm_pkg::rrsm_count_t limit;
        if (cycles > ((32'h1 << `RRSM_COUNT_W) - 32'h1)) begin
            limit = '1;
        end else begin
            limit = rrsm_pkg::rrsm_count_t'(cycles);
        end
        return limit;
    endfunction

    // Counter hold and lost flag must agree on the end point
    function automatic logic count_at_limit(
        input rrsm_pkg::rrsm_count_t cnt,
        input rrsm_pkg::rrsm_count_t lim
    );
        return cnt == lim;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic ref_level;
    logic ref_rise;
    logic tick_rise;
    logic dis_level;
    logic btn_rise;

    // Every pin but rst and remote_clear passes two flops before any logic reads it
    rrsm_sync_edge u_ref (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .async_in   (ref_10m_in),
        .level_out  (ref_level),
        .rise_pulse (ref_rise)
    );

    rrsm_sync_edge u_tick (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .async_in   (second_tick_pulse),
        .level_out  (),
        .rise_pulse (tick_rise)
    );

    rrsm_sync_edge u_dis (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .async_in   (sync_enable),
        .level_out  (dis_level),
        .rise_pulse ()
    );

    rrsm_sync_edge u_btn (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .async_in   (panel_clear_btn),
        .level_out  (),
        .rise_pulse (btn_rise)
    );

    // ----------------------------------------------------------------
    // Re-timed 10 MHz output
    // ----------------------------------------------------------------
    logic ref_10m_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ref_10m_reg <= 1'h0;
        end else begin
            ref_10m_reg <= ref_level;
        end
    end

    // ----------------------------------------------------------------
    // Phase monitor
    // ----------------------------------------------------------------
    logic div_reg;
    logic phase_err;
    logic phase_wrong_reg;

    // Wrong phase means the divider is high at the tick edge
    assign phase_err = tick_rise & div_reg;

    // Holds the phase seen at the last tick for the host
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_wrong_reg <= 1'h0;
        end else if (tick_rise) begin
            phase_wrong_reg <= div_reg;
        end
    end

    // ----------------------------------------------------------------
    // Divide-by-two
    // ----------------------------------------------------------------
    // Tick reset wins over a coincident 10 MHz edge so the phase is forced, but only while dis_level is low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_reg <= `RRSM_DIV_RST;
        end else if (phase_err && !dis_level) begin
            div_reg <= 1'h0;
        end else if (ref_rise) begin
            div_reg <= ~div_reg;
        end
    end

    // ----------------------------------------------------------------
    // Tick watchdog
    // ----------------------------------------------------------------
    rrsm_pkg::rrsm_count_t tick_cnt_reg;
    logic                  tick_lost_reg;
    rrsm_pkg::rrsm_count_t timeout_lim;

    assign timeout_lim = clamp_limit(PPS_TIMEOUT_CYC);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_reg <= '0;
        end else if (tick_rise) begin
            tick_cnt_reg <= '0;
        end else if (ref_rise && !count_at_limit(tick_cnt_reg, timeout_lim)) begin
            tick_cnt_reg <= tick_cnt_reg + 1'h1;
        end
    end

    // Only 10 MHz edges advance it, so a dead reference cannot time out
    // A tick in the limit cycle wins: the pulse did arrive
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_lost_reg <= 1'h0;
        end else if (tick_rise) begin
            tick_lost_reg <= 1'h0;
        end else if (count_at_limit(tick_cnt_reg, timeout_lim)) begin
            tick_lost_reg <= 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // Sync fault latch
    // ----------------------------------------------------------------
    rrsm_pkg::rrsm_cause_t cause;
    logic                  fault_reg;
    logic                  clear_req;

    always_comb begin
        cause = `RRSM_CAUSE_RST;
        cause[`RRSM_CAUSE_PHASE]    = phase_err;
        cause[`RRSM_CAUSE_LOST]     = tick_lost_reg;
        cause[`RRSM_CAUSE_DISABLED] = dis_level;
    end

    // Host pulse comes from same-clock logic, so no synchroniser
    assign clear_req = remote_clear | btn_rise;

    // Powers up faulted; a cause present in the clear cycle wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_reg <= `RRSM_FAULT_RST;
        end else if (|cause) begin
            fault_reg <= 1'h1;
        end else if (clear_req) begin
            fault_reg <= 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic led_reg;

    // Registered so the indicator never glitches on a cause
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            led_reg <= 1'h0;
        end else begin
            led_reg <= ~fault_reg;
        end
    end

    assign ref_10m_out   = ref_10m_reg;
    assign ref_5m_out    = div_reg;
    assign sync_fault    = fault_reg;
    assign sync_good_led = led_reg;
    assign tick_lost     = tick_lost_reg;
    assign phase_wrong   = phase_wrong_reg;
endmodule
